/* File: verilog/fpl_perp_lock_ctrl.v */
// What this block does
// - any reset returns to conventional mode, both global mode bits zero.
// - 1 Mbps perpendicular mode uses 41-byte post-id gap, else 22.
// - conventional read enables the oscillator 24 bytes into the gap.
// - 1 Mbps perpendicular read enables the oscillator at 43 bytes.
// - oscillator enable rises about two bytes into the sync field.
// - conventional write raises write gate at sync field start.
// - 1 Mbps perpendicular write writes 38 bytes inside the gap.
// - 500 Kbps perpendicular write writes 19 bytes inside the gap.
// - with global bits zero, set per-drive bits make drives perpendicular.
// - per-drive perpendicular write writes 19 bytes inside the gap at 500 Kbps, selects a 38-byte lead at 1 Mbps, none at other rates.
// - per-drive perpendicular writes use zero precompensation.
// - other drives use the programmed precompensation value.
// - per-drive bits change only on hardware reset or when overwrite enable is one.
// - any global mode bit set makes per-drive bits ignored.
// - software reset clears the global mode bits, not the per-drive bits.
// - hardware reset clears global and per-drive bits.
// - with lock set, software reset keeps fifo and pretrack settings.
// - hardware reset clears lock and restores fifo and pretrack defaults.
// - lock command returns one result byte holding the new lock bit.
// - dump command's eighth byte carries lock and per-drive bits.
// - hardware reset leaves legacy-compatible defaults from host-type straps.
// - default fifo threshold is one byte, fifo disabled.
// - default precompensation start track is zero.
`timescale 1ns/10ps
`default_nettype none
`include "fpl_defs.vh"
module fpl_perp_lock_ctrl #(
  parameter NDRV = 4
) (
  // clock and resets
  input wire i_clk,
  input wire i_rst,
  input wire i_sw_rst,
  // command byte handshake
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_byte,
  output wire o_cmd_ready,
  output wire o_res_valid,
  output wire [7:0] o_res_byte,
  input wire i_res_ack,
  // configure command inputs
  input wire i_cfg_wr,
  input wire i_cfg_fifo_dis,
  input wire [3:0] i_cfg_fifo_thr,
  input wire [7:0] i_cfg_precomp_start_track,
  // legacy mode straps from firmware
  input wire i_host_type,
  input wire i_enc_mfm,
  // operation context
  input wire [1:0] i_data_rate,
  input wire [1:0] i_drive_sel,
  input wire [2:0] i_precomp_prog,
  input wire i_in_gap2,
  input wire i_gap_byte_tick,
  input wire i_write_op,
  // derived outputs
  output wire [7:0] o_gap2_len,
  output wire o_osc_lock_enable,
  output wire o_write_gate,
  output wire [2:0] o_precomp,
  output wire o_drive_perp,
  output wire o_fifo_disable_bit,
  output wire [3:0] o_fifo_threshold,
  output wire [7:0] o_precomp_start_track,
  output wire o_lock,
  output wire [NDRV-1:0] o_per_drive_perp_bits,
  output wire o_legacy_host_type,
  output wire o_legacy_mfm
);
  localparam ST_IDLE = 2'd0;
  localparam ST_PERP = 2'd1;
  localparam ST_RES = 2'd2;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg ready_ff;
  reg perp_rate_select_high_ff;
  reg gap_sel_ff;
  reg [NDRV-1:0] drv_ff;
  reg lock_ff;
  reg fifo_dis_ff;
  reg [3:0] thr_ff;
  reg [7:0] precomp_start_track_ff;
  reg res_valid_ff;
  reg [7:0] res_byte_ff;
  reg [7:0] dump_byte;
  reg [3:0] dump_idx_ff;
  reg host_ff;
  reg mfm_ff;
  reg [7:0] gap2_ff;
  reg [7:0] gap_cnt_ff;
  reg [7:0] wg_lead_ff;
  reg osc_ff;
  reg wg_ff;
  reg drvp_ff;
  reg [2:0] precomp_ff;
  reg rst_q_ff;

  wire glob_any = perp_rate_select_high_ff | gap_sel_ff;
  wire drv_perp = !glob_any && drv_ff[i_drive_sel];
  wire perp1m = perp_rate_select_high_ff & gap_sel_ff;
  wire perp500 = gap_sel_ff & ~perp_rate_select_high_ff; // table encoding taken
  wire take = i_cmd_valid && (state_ff != ST_RES);
  wire perp_prm = (state_ff == ST_PERP) && take;
  wire lock_cmd = (state_ff == ST_IDLE) && take && (i_cmd_byte[4:0] == `FPL_CMD_LOCK_LO);
  wire dump_cmd = (state_ff == ST_IDLE) && take && (i_cmd_byte == `FPL_CMD_DUMP);
  reg [7:0] vco_at;
  reg [7:0] wg_lead;
  reg [7:0] gap2_len;

  always @* begin
    gap2_len = perp1m ? `FPL_GAP2_PERP1M : `FPL_GAP2_CONV;
    vco_at = perp1m ? `FPL_VCO_PERP1M : `FPL_VCO_CONV;
    if (perp1m) begin
      wg_lead = `FPL_WG_PERP1M;
    end else if (perp500) begin
      wg_lead = `FPL_WG_PERP500;
    end else if (drv_perp) begin
      wg_lead = (i_data_rate == `FPL_RATE_1M) ? `FPL_WG_PERP1M :
                (i_data_rate == `FPL_RATE_500K) ? `FPL_WG_PERP500 : `FPL_WG_NONE;
    end else begin
      wg_lead = `FPL_WG_NONE;
    end
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take && i_cmd_byte == `FPL_CMD_PERP) begin
          nxt_state = ST_PERP;
        end else if (take && (i_cmd_byte[4:0] == `FPL_CMD_LOCK_LO || i_cmd_byte == `FPL_CMD_DUMP)) begin
          nxt_state = ST_RES;
        end
      end
      ST_PERP: begin
        if (take) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RES: begin
        if (res_valid_ff && i_res_ack && dump_idx_ff == 4'd0) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ready is registered so the port comes straight from a flip-flop
  always @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      ready_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= (nxt_state != ST_RES);
    end
  end

  always @(posedge i_clk) begin
    rst_q_ff <= i_rst;
  end

  // global mode bits and per-drive bits
  always @(posedge i_clk) begin
    if (i_rst) begin
      perp_rate_select_high_ff <= 1'b0;
      gap_sel_ff <= 1'b0;
      drv_ff <= {NDRV{1'b0}};
    end else if (i_sw_rst) begin
      // software reset wins over a parameter byte in the same cycle
      perp_rate_select_high_ff <= 1'b0;
      gap_sel_ff <= 1'b0;
    end else if (perp_prm) begin
      perp_rate_select_high_ff <= i_cmd_byte[`FPL_PERP_PERP_RATE_SELECT_HIGH];
      gap_sel_ff <= i_cmd_byte[`FPL_PERP_GAP];
      if (i_cmd_byte[`FPL_PERP_OW]) begin
        drv_ff <= i_cmd_byte[NDRV+1:2];
      end
    end
  end

  // fifo and pretrack settings, kept over software reset while locked
  always @(posedge i_clk) begin
    if (i_rst) begin
      fifo_dis_ff <= `FPL_RST_FIFO_DIS;
      thr_ff <= `FPL_RST_FIFO_THR;
      precomp_start_track_ff <= `FPL_RST_PRECOMP_START_TRACK;
    end else if (i_sw_rst) begin
      if (!lock_ff) begin
        fifo_dis_ff <= `FPL_RST_FIFO_DIS;
        thr_ff <= `FPL_RST_FIFO_THR;
        precomp_start_track_ff <= `FPL_RST_PRECOMP_START_TRACK;
      end
    end else if (i_cfg_wr) begin
      fifo_dis_ff <= i_cfg_fifo_dis;
      thr_ff <= i_cfg_fifo_thr;
      precomp_start_track_ff <= i_cfg_precomp_start_track;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      lock_ff <= 1'b0;
    end else if (lock_cmd) begin
      lock_ff <= i_cmd_byte[`FPL_LOCK_BIT];
    end
  end

  // dump bytes are counted down; the byte loaded at index k is shown at k-1
  // so loading at index 3 makes index 2 the eighth of ten
  always @* begin
    dump_byte = 8'h00;
    case (dump_idx_ff)
      4'd3: begin
        dump_byte = {lock_ff, {(6-NDRV){1'b0}}, gap_sel_ff, drv_ff};
      end
      4'd2: begin
        dump_byte = {fifo_dis_ff, 3'b000, thr_ff};
      end
      4'd1: begin
        dump_byte = precomp_start_track_ff;
      end
      default: begin
        dump_byte = 8'h00;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      res_valid_ff <= 1'b0;
      res_byte_ff <= 8'h00;
      dump_idx_ff <= 4'h0;
    end else if (lock_cmd) begin
      res_valid_ff <= 1'b1;
      res_byte_ff <= {3'b000, i_cmd_byte[`FPL_LOCK_BIT], 4'h0};
      dump_idx_ff <= 4'h0;
    end else if (dump_cmd) begin
      res_valid_ff <= 1'b1;
      res_byte_ff <= 8'h00;
      dump_idx_ff <= 4'd9;
    end else if (res_valid_ff && i_res_ack) begin
      if (dump_idx_ff == 4'd0) begin
        res_valid_ff <= 1'b0;
      end else begin
        dump_idx_ff <= dump_idx_ff - 4'd1;
        res_byte_ff <= dump_byte;
      end
    end
  end

  // mode-derived values, settled before a gap starts
  always @(posedge i_clk) begin
    if (i_rst) begin
      gap2_ff <= `FPL_GAP2_CONV;
      wg_lead_ff <= `FPL_WG_NONE;
      drvp_ff <= 1'b0;
      precomp_ff <= 3'h0;
    end else begin
      gap2_ff <= gap2_len;
      wg_lead_ff <= wg_lead;
      drvp_ff <= drv_perp;
      precomp_ff <= drv_perp ? 3'h0 : i_precomp_prog;
    end
  end

  // gap2 byte position drives oscillator and write gate timing
  always @(posedge i_clk) begin
    if (i_rst) begin
      gap_cnt_ff <= 8'h00;
      osc_ff <= 1'b0;
      wg_ff <= 1'b0;
    end else if (!i_in_gap2) begin
      gap_cnt_ff <= 8'h00;
      osc_ff <= 1'b0;
      wg_ff <= 1'b0;
    end else if (i_gap_byte_tick) begin
      gap_cnt_ff <= gap_cnt_ff + 8'd1;
      if (!i_write_op && gap_cnt_ff + 8'd1 == vco_at) begin
        osc_ff <= 1'b1;
      end
      // the lead is counted back from the end of the gap
      if (i_write_op && wg_lead_ff != `FPL_WG_NONE && gap_cnt_ff + 8'd1 + wg_lead_ff == gap2_ff) begin
        wg_ff <= 1'b1;
      end
      if (i_write_op && gap_cnt_ff + 8'd1 == gap2_ff) begin
        wg_ff <= 1'b1;
      end
    end
  end

  // legacy straps caught on reset release, never under reset
  always @(posedge i_clk) begin
    if (rst_q_ff && !i_rst) begin
      host_ff <= i_host_type;
      mfm_ff <= i_enc_mfm;
    end
  end

  assign o_cmd_ready = ready_ff;
  assign o_res_valid = res_valid_ff;
  assign o_res_byte = res_byte_ff;
  assign o_gap2_len = gap2_ff;
  assign o_osc_lock_enable = osc_ff;
  assign o_write_gate = wg_ff;
  assign o_precomp = precomp_ff;
  assign o_drive_perp = drvp_ff;
  assign o_fifo_disable_bit = fifo_dis_ff;
  assign o_fifo_threshold = thr_ff;
  assign o_precomp_start_track = precomp_start_track_ff;
  assign o_lock = lock_ff;
  assign o_per_drive_perp_bits = drv_ff;
  assign o_legacy_host_type = host_ff;
  assign o_legacy_mfm = mfm_ff;
endmodule
`default_nettype wire

/* File: verilog/fpl_defs.vh */
`ifndef FPL_DEFS_VH
`define FPL_DEFS_VH
// gap2 lengths and write-gate lead in bytes
`define FPL_GAP2_CONV 8'h16
`define FPL_GAP2_PERP1M 8'h29
`define FPL_VCO_CONV 8'h18
`define FPL_VCO_PERP1M 8'h2B
`define FPL_WG_PERP1M 8'h26
`define FPL_WG_PERP500 8'h13
`define FPL_WG_NONE 8'h00
// command codes and field positions
`define FPL_CMD_PERP 8'h12
`define FPL_CMD_LOCK_LO 5'h14
`define FPL_CMD_DUMP 8'h0E
`define FPL_LOCK_BIT 7
`define FPL_PERP_OW 7
`define FPL_PERP_GAP 0
`define FPL_PERP_PERP_RATE_SELECT_HIGH 1
// reset values
`define FPL_RST_FIFO_DIS 1'b1
`define FPL_RST_FIFO_THR 4'h0
`define FPL_RST_PRECOMP_START_TRACK 8'h00
// data rate codes
`define FPL_RATE_1M 2'h3
`define FPL_RATE_500K 2'h0
`endif

/* File: test/fpl_perp_lock_ctrl_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module fpl_perp_lock_ctrl_asserts #(parameter NDRV = 4) (
  input wire i_clk, i_rst, i_sw_rst, i_cmd_valid, o_cmd_ready, o_res_valid, i_in_gap2, i_gap_byte_tick,
  input wire o_osc_lock_enable, o_write_gate, o_drive_perp, o_lock,
  input wire [7:0] i_cmd_byte, o_res_byte, o_gap2_len,
  input wire [2:0] o_precomp,
  input wire [NDRV-1:0] o_per_drive_perp_bits
);
  reg [7:0] cnt_ff;
  reg prm_ff;
  // a parameter byte must not be mistaken for a lock command
  always @(posedge i_clk) begin
    cnt_ff <= i_in_gap2 ? cnt_ff + {7'h00, i_gap_byte_tick} : 8'h00;
    prm_ff <= !i_rst && i_cmd_valid && o_cmd_ready && !prm_ff && i_cmd_byte == 8'h12;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_lock_cmd;
    i_cmd_valid && o_cmd_ready && !prm_ff && i_cmd_byte[4:0] == 5'h14;
  endsequence
  a_reset_conv: assert property (disable iff (1'b0) i_rst [*2] |=> o_gap2_len == 8'h16 && !o_lock
    && o_per_drive_perp_bits == '0) else $error("reset state");
  a_lock_answer: assert property (s_lock_cmd |=> o_res_valid
    && o_res_byte == {3'h0, $past(i_cmd_byte[7]), 4'h0}) else $error("lock byte");
  a_refuse_pend: assert property (o_res_valid |-> !o_cmd_ready) else $error("ready early");
  a_precomp_zero: assert property (o_drive_perp |-> o_precomp == 3'h0) else $error("precomp");
  a_osc_start: assert property ($rose(o_osc_lock_enable) |->
    cnt_ff == (o_gap2_len == 8'h29 ? 8'h2B : 8'h18)) else $error("osc start");
  a_osc_drop: assert property (!i_in_gap2 |=> !o_osc_lock_enable) else $error("osc drop");
  a_perp_rate_select_high_lead: assert property ($rose(o_write_gate) && !o_drive_perp |->
    cnt_ff == 8'h03 || cnt_ff == 8'h16) else $error("write gate");
  a_soft_keep: assert property (i_sw_rst |=> $stable(o_per_drive_perp_bits) ##1
    o_gap2_len == 8'h16) else $error("soft reset");
endmodule
bind fpl_perp_lock_ctrl fpl_perp_lock_ctrl_asserts #(.NDRV(NDRV)) fpl_perp_lock_ctrl_asserts_i (.*);
`default_nettype wire

/* File: test/fpl_drive_model.sv */
`timescale 1ns/10ps
`default_nettype none
// media side: one gap2 pass of i_len bytes, a byte every four clocks
module fpl_drive_model (
  input wire logic i_clk, i_rst, i_start,
  input wire logic [7:0] i_len,
  output logic o_in_gap2, o_tick,
  output logic [7:0] o_bytes
);
  logic [1:0] div_ff;
  always @(posedge i_clk) begin
    div_ff <= i_rst ? 2'h0 : div_ff + 2'h1;
    o_tick <= o_in_gap2 && div_ff == 2'h3;
    if (i_rst || o_tick && o_bytes + 8'h01 == i_len) o_in_gap2 <= 1'b0;
    else if (i_start) o_in_gap2 <= 1'b1;
    if (i_rst || i_start) o_bytes <= 8'h00;
    else if (o_tick) o_bytes <= o_bytes + 8'h01;
  end
endmodule
`default_nettype wire

/* File: test/test_fpl_perp_lock_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module test_fpl_perp_lock_ctrl;
  logic i_clk = 0, i_rst = 0, i_sw_rst = 0, i_cmd_valid = 0, i_res_ack = 0, i_cfg_wr = 0, i_cfg_fifo_dis = 1;
  logic i_host_type = 1, i_enc_mfm = 0, i_write_op = 0, start = 0;
  logic [7:0] i_cmd_byte = 8'h00, i_cfg_precomp_start_track = 8'h00;
  logic [3:0] i_cfg_fifo_thr = 4'h0;
  logic [2:0] i_precomp_prog = 3'h0;
  logic [1:0] i_data_rate = 2'h0, i_drive_sel = 2'h0;
  wire i_in_gap2, i_gap_byte_tick, o_cmd_ready, o_res_valid, o_osc_lock_enable, o_write_gate, o_drive_perp;
  wire o_fifo_disable_bit, o_lock, o_legacy_host_type, o_legacy_mfm;
  wire [7:0] bytes, o_res_byte, o_gap2_len, o_precomp_start_track;
  wire [3:0] o_fifo_threshold, o_per_drive_perp_bits;
  wire [2:0] o_precomp;
  int err_count = 0, comparisons = 0;
  fpl_perp_lock_ctrl #(.NDRV(4)) fpl_perp_lock_ctrl_i (.*);
  fpl_drive_model fpl_drive_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_start(start), .i_len(8'h2D),
    .o_in_gap2(i_in_gap2), .o_tick(i_gap_byte_tick), .o_bytes(bytes));
  always #2 i_clk = ~i_clk;
  task automatic chk(input string nm, input [7:0] e, input [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input [7:0] b);
    i_cmd_valid <= 1'b1; i_cmd_byte <= b; @(posedge i_clk); i_cmd_valid <= 1'b0; #1;
  endtask
  // valid stays up across the pair so it is never driven twice in one step
  task automatic cmd2(input [7:0] a, input [7:0] b);
    i_cmd_valid <= 1'b1; i_cmd_byte <= a; @(posedge i_clk); cmd(b);
  endtask
  task automatic ack(input int n);
    repeat (n) begin
      i_res_ack <= 1'b1; @(posedge i_clk); i_res_ack <= 1'b0; @(posedge i_clk); #1;
    end
  endtask
  task automatic soft_reset;
    i_sw_rst <= 1'b1; @(posedge i_clk); i_sw_rst <= 1'b0; repeat (2) @(posedge i_clk); #1;
  endtask
  task automatic hw_reset;
    i_rst <= 1'b1; repeat (12) @(posedge i_clk); i_rst <= 1'b0; repeat (2) @(posedge i_clk); #1;
    chk("gap2", 8'h16, o_gap2_len);
    chk("drv bits", 8'h00, {4'h0, o_per_drive_perp_bits});
    chk("lock", 8'h00, {7'h0, o_lock});
    chk("fifo", 8'h10, {3'h0, o_fifo_disable_bit, o_fifo_threshold});
    chk("precomp_start_track", 8'h00, o_precomp_start_track);
    chk("straps", 8'h02, {6'h0, o_legacy_host_type, o_legacy_mfm});
    $display("reset test done");
  endtask
  task automatic gap_run(input [7:0] prm, input wr, input [1:0] rate, input [7:0] glen, input [7:0] at);
    logic [7:0] seen;
    seen = 8'hFF;
    i_data_rate <= rate;
    cmd2(8'h12, prm);
    i_write_op <= wr; start <= 1'b1; @(posedge i_clk); start <= 1'b0;
    repeat (200) begin
      @(posedge i_clk); #1;
      if ((wr ? o_write_gate : o_osc_lock_enable) === 1'b1 && seen == 8'hFF) seen = bytes;
    end
    chk("gap2", glen, o_gap2_len);
    chk("event byte", at, seen);
    i_write_op <= 1'b0; @(posedge i_clk); #1;
    $display("gap test done");
  endtask
  task automatic drive_test;
    i_precomp_prog <= 3'h5; cmd2(8'h12, 8'h84);
    repeat (3) @(posedge i_clk); #1;
    chk("drv perp", 8'h01, {7'h0, o_drive_perp});
    chk("precomp", 8'h00, {5'h0, o_precomp});
    i_drive_sel <= 2'h1; repeat (3) @(posedge i_clk); #1;
    chk("precomp", 8'h05, {5'h0, o_precomp});
    cmd2(8'h12, 8'h3C); cmd2(8'h12, 8'h03); i_drive_sel <= 2'h0; repeat (3) @(posedge i_clk); #1;
    chk("drv bits", 8'h01, {4'h0, o_per_drive_perp_bits});
    chk("drv perp", 8'h00, {7'h0, o_drive_perp});
    soft_reset;
    chk("gap2", 8'h16, o_gap2_len);
    chk("drv bits", 8'h01, {4'h0, o_per_drive_perp_bits});
    $display("drive test done");
  endtask
  task automatic lock_test;
    i_cfg_wr <= 1'b1; i_cfg_fifo_thr <= 4'h5; i_cfg_precomp_start_track <= 8'h07; i_cfg_fifo_dis <= 1'b0;
    @(posedge i_clk); i_cfg_wr <= 1'b0;
    cmd(8'h94);
    chk("lock res", 8'h10, o_res_byte);
    chk("ready", 8'h00, {7'h0, o_cmd_ready});
    ack(1); soft_reset;
    chk("thr", 8'h05, {4'h0, o_fifo_threshold});
    chk("precomp_start_track", 8'h07, o_precomp_start_track);
    cmd(8'h0E); ack(7);
    chk("dump 8", 8'h81, o_res_byte);
    ack(3);
    $display("lock test done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000; err_count++; report_and_stop;
  end
  initial begin
    hw_reset;
    gap_run(8'h00, 1'b0, 2'h0, 8'h16, 8'h18);
    gap_run(8'h03, 1'b0, 2'h3, 8'h29, 8'h2B);
    gap_run(8'h03, 1'b1, 2'h3, 8'h29, 8'h03);
    gap_run(8'h01, 1'b1, 2'h0, 8'h16, 8'h03);
    gap_run(8'h00, 1'b1, 2'h0, 8'h16, 8'h16);
    drive_test;
    lock_test;
    hw_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire
